//--- src/eag_pkg.sv
// eag_pkg: shared constants, modes and carriers of the effective address generator.
// assumes one core clock, a synchronous active-high reset, and a decoder that presents requests.
// ==========================================================================
// How it works
// - direct register mode: operand is general register n, no memory address formed.
// - indirect mode: address is general register n unchanged.
// - post-increment: address is old register n, then add 1/2/4 by size.
// - pre-decrement: subtract 1/2/4 by size, write back, address with result.
// - 4-bit offset zero-extended, scaled 1/2/4 by size, added to register n.
// - indexed: register n plus index register zero, unscaled.
// - 8-bit offset zero-extended, scaled 1/2/4, added to global base register.
// - indexed base: global base register plus index register zero, unscaled.
// - pc data load: 8-bit offset zero-extended, doubled/quadrupled, plus pc; no byte.
// - longword pc data load clears the two low pc bits first.
// - short branch: 8-bit offset sign-extended, doubled, plus pc.
// - long branch: 12-bit offset sign-extended, doubled, plus pc.
// - register branch: pc plus full general register n.
// - logic and bit test literals: 8-bit field zero-extended to 32 bits.
// - transfer, add, equality compare literals: 8-bit field sign-extended to 32 bits.
// - software trap: 8-bit literal zero-extended and multiplied by four.
package eag_pkg;

   // ========================================================================
   // widths
   localparam int EAG_DATA_W = 32;
   localparam int EAG_FIELD_W = 12;
   localparam int EAG_DISP4_W = 4;
   localparam int EAG_DISP8_W = 8;
   localparam int EAG_DISP12_W = 12;

   // ========================================================================
   // scaling and masks
   localparam logic [1:0] EAG_SHIFT_BYTE = 2'h0;
   localparam logic [1:0] EAG_SHIFT_WORD = 2'h1;
   localparam logic [1:0] EAG_SHIFT_LONG = 2'h2;
   localparam logic [1:0] EAG_SHIFT_BRANCH = 2'h1;
   localparam logic [1:0] EAG_SHIFT_TRAP = 2'h2;
   localparam logic [31:0] EAG_STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] EAG_STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] EAG_STEP_LONG = 32'h0000_0004;
   localparam logic [31:0] EAG_PC_LONG_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] EAG_ZERO = 32'h0000_0000;

   // ========================================================================
   // modes and sizes
   typedef enum logic [3:0] {
      EAG_M_DIRECT,
      EAG_M_INDIRECT,
      EAG_M_POSTINC,
      EAG_M_PREDEC,
      EAG_M_DISP4,
      EAG_M_INDEXED,
      EAG_M_GBR_DISP8,
      EAG_M_GBR_INDEXED,
      EAG_M_PC_DISP8,
      EAG_M_BR_DISP8,
      EAG_M_BR_DISP12,
      EAG_M_BR_REG,
      EAG_M_IMM_ZX,
      EAG_M_IMM_SX,
      EAG_M_IMM_TRAP
   } eag_mode_t;

   typedef enum logic [1:0] {
      EAG_SZ_BYTE,
      EAG_SZ_WORD,
      EAG_SZ_LONG
   } eag_size_t;

   // ========================================================================
   // carriers
   typedef struct packed {
      eag_mode_t mode;
      eag_size_t size;
      logic [EAG_FIELD_W-1:0] field;
      logic [EAG_DATA_W-1:0] gen_reg_n;
      logic [EAG_DATA_W-1:0] index_reg_zero;
      logic [EAG_DATA_W-1:0] global_base_reg;
      logic [EAG_DATA_W-1:0] pc;
   } eag_req_t;

   typedef struct packed {
      logic mem_en;
      logic branch_en;
      logic [EAG_DATA_W-1:0] addr;
      logic wb_en;
      logic [EAG_DATA_W-1:0] wb_value;
      logic operand_en;
      logic [EAG_DATA_W-1:0] operand;
      logic illegal;
   } eag_res_t;

endpackage

//--- src/eag_zscale.sv
// eag_zscale: zero-extends an offset or literal field and shifts it left.
// assumes the shift amount comes from the size decode of the caller or is a fixed constant.
`timescale 1ns/1ps
module eag_zscale
   import eag_pkg::*;
#(
   parameter int FIELD_W = 8,
   parameter int DATA_W = 32
) (
   input wire logic [FIELD_W-1:0] i_field,
   input wire logic [1:0] i_shift,
   output logic [DATA_W-1:0] o_value
);
   // ========================================================================
   // elaboration check
   if (FIELD_W < 1 || FIELD_W + 2 > DATA_W) begin : g_bad
      $error("eag_zscale: field width does not fit the data width");
   end

   wire logic [DATA_W-1:0] zext;
   assign zext = {{(DATA_W-FIELD_W){1'b0}}, i_field};
   assign o_value = zext << i_shift;
endmodule // eag_zscale

//--- src/eag_sxt2.sv
// eag_sxt2: sign-extends an offset or literal field and shifts it left by i_shift.
// assumes the field is two's complement and the result wraps at the data width.
`timescale 1ns/1ps
module eag_sxt2
   import eag_pkg::*;
#(
   parameter int FIELD_W = 8,
   parameter int DATA_W = 32
) (
   input wire logic [FIELD_W-1:0] i_field,
   input wire logic [1:0] i_shift,
   output logic [DATA_W-1:0] o_value
);
   // ========================================================================
   // elaboration check
   if (FIELD_W < 2 || FIELD_W + 2 > DATA_W) begin : g_bad
      $error("eag_sxt2: field width does not fit the data width");
   end

   wire logic [DATA_W-1:0] sext;
   assign sext = {{(DATA_W-FIELD_W){i_field[FIELD_W-1]}}, i_field};
   assign o_value = sext << i_shift;
endmodule // eag_sxt2

//--- src/eag_core.sv
// eag_core: effective address, write-back and literal operand generator.
// assumes the decoder supplies register values and the raw field with a one-cycle valid.
// results appear one cycle after the request, held until the next request; done is high for that one cycle only.
`timescale 1ns/1ps
module eag_core
   import eag_pkg::*;
#(
   parameter int DATA_W = EAG_DATA_W
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire eag_req_t i_req,
   output logic o_done,
   output logic o_mem_en,
   output logic o_branch_en,
   output logic [DATA_W-1:0] o_addr,
   output logic o_wb_en,
   output logic [DATA_W-1:0] o_wb_value,
   output logic o_operand_en,
   output logic [DATA_W-1:0] o_operand,
   output logic o_illegal
);
   // ========================================================================
   // elaboration check
   if (DATA_W != EAG_DATA_W) begin : g_bad
      $error("eag_core: data width must match the carrier width");
   end

   // ========================================================================
   // request fields
   wire logic [DATA_W-1:0] rn;
   wire logic [DATA_W-1:0] r0;
   wire logic [DATA_W-1:0] global_base_register;
   wire logic [DATA_W-1:0] pc;
   wire logic [EAG_DISP4_W-1:0] f4;
   wire logic [EAG_DISP8_W-1:0] f8;
   wire logic [EAG_DISP12_W-1:0] f12;
   assign rn = i_req.gen_reg_n;
   assign r0 = i_req.index_reg_zero;
   assign global_base_register = i_req.global_base_reg;
   assign pc = i_req.pc;
   assign f4 = i_req.field[EAG_DISP4_W-1:0];
   assign f8 = i_req.field[EAG_DISP8_W-1:0];
   assign f12 = i_req.field[EAG_DISP12_W-1:0];

   // ========================================================================
   // mode decode
   wire logic m_direct;
   wire logic m_indirect;
   wire logic m_postinc;
   wire logic m_predec;
   wire logic m_disp4;
   wire logic m_indexed;
   wire logic m_gbr_disp;
   wire logic m_gbr_idx;
   wire logic m_pc_disp;
   wire logic m_br8;
   wire logic m_br12;
   wire logic m_brreg;
   wire logic m_imm_zx;
   wire logic m_imm_sx;
   wire logic m_trap;
   assign m_direct = (i_req.mode == EAG_M_DIRECT);
   assign m_indirect = (i_req.mode == EAG_M_INDIRECT);
   assign m_postinc = (i_req.mode == EAG_M_POSTINC);
   assign m_predec = (i_req.mode == EAG_M_PREDEC);
   assign m_disp4 = (i_req.mode == EAG_M_DISP4);
   assign m_indexed = (i_req.mode == EAG_M_INDEXED);
   assign m_gbr_disp = (i_req.mode == EAG_M_GBR_DISP8);
   assign m_gbr_idx = (i_req.mode == EAG_M_GBR_INDEXED);
   assign m_pc_disp = (i_req.mode == EAG_M_PC_DISP8);
   assign m_br8 = (i_req.mode == EAG_M_BR_DISP8);
   assign m_br12 = (i_req.mode == EAG_M_BR_DISP12);
   assign m_brreg = (i_req.mode == EAG_M_BR_REG);
   assign m_imm_zx = (i_req.mode == EAG_M_IMM_ZX);
   assign m_imm_sx = (i_req.mode == EAG_M_IMM_SX);
   assign m_trap = (i_req.mode == EAG_M_IMM_TRAP);

   // ========================================================================
   // size decode
   wire logic sz_byte;
   wire logic sz_word;
   wire logic sz_long;
   wire logic sz_bad;
   assign sz_byte = (i_req.size == EAG_SZ_BYTE);
   assign sz_word = (i_req.size == EAG_SZ_WORD);
   assign sz_long = (i_req.size == EAG_SZ_LONG);
   assign sz_bad = !(sz_byte || sz_word || sz_long);

   wire logic [1:0] size_shift;
   wire logic [DATA_W-1:0] size_step;
   assign size_shift = sz_long ? EAG_SHIFT_LONG :
                       sz_word ? EAG_SHIFT_WORD : EAG_SHIFT_BYTE;
   assign size_step = sz_long ? EAG_STEP_LONG :
                      sz_word ? EAG_STEP_WORD : EAG_STEP_BYTE;

   // ========================================================================
   // scaled offsets and literals
   wire logic [DATA_W-1:0] disp4_sc;
   wire logic [DATA_W-1:0] disp8_sc;
   wire logic [DATA_W-1:0] br8_off;
   wire logic [DATA_W-1:0] br12_off;
   wire logic [DATA_W-1:0] imm_zx;
   wire logic [DATA_W-1:0] imm_sx;
   wire logic [DATA_W-1:0] trap_off;

   eag_zscale #(.FIELD_W(EAG_DISP4_W), .DATA_W(DATA_W)) u_disp4 (
      .i_field(f4),
      .i_shift(size_shift),
      .o_value(disp4_sc)
   );

   eag_zscale #(.FIELD_W(EAG_DISP8_W), .DATA_W(DATA_W)) u_disp8 (
      .i_field(f8),
      .i_shift(size_shift),
      .o_value(disp8_sc)
   );

   eag_sxt2 #(.FIELD_W(EAG_DISP8_W), .DATA_W(DATA_W)) u_br8 (
      .i_field(f8),
      .i_shift(EAG_SHIFT_BRANCH),
      .o_value(br8_off)
   );

   eag_sxt2 #(.FIELD_W(EAG_DISP12_W), .DATA_W(DATA_W)) u_br12 (
      .i_field(f12),
      .i_shift(EAG_SHIFT_BRANCH),
      .o_value(br12_off)
   );

   eag_zscale #(.FIELD_W(EAG_DISP8_W), .DATA_W(DATA_W)) u_immzx (
      .i_field(f8),
      .i_shift(EAG_SHIFT_BYTE),
      .o_value(imm_zx)
   );

   eag_sxt2 #(.FIELD_W(EAG_DISP8_W), .DATA_W(DATA_W)) u_immsx (
      .i_field(f8),
      .i_shift(EAG_SHIFT_BYTE),
      .o_value(imm_sx)
   );

   eag_zscale #(.FIELD_W(EAG_DISP8_W), .DATA_W(DATA_W)) u_trap (
      .i_field(f8),
      .i_shift(EAG_SHIFT_TRAP),
      .o_value(trap_off)
   );

   // ========================================================================
   // per-mode addresses, all wrapping at the data width
   wire logic [DATA_W-1:0] pc_base;
   wire logic [DATA_W-1:0] ea_predec;
   wire logic [DATA_W-1:0] wb_postinc;
   wire logic [DATA_W-1:0] ea_disp4;
   wire logic [DATA_W-1:0] ea_indexed;
   wire logic [DATA_W-1:0] ea_gbr_disp;
   wire logic [DATA_W-1:0] ea_gbr_idx;
   wire logic [DATA_W-1:0] ea_pc_disp;
   wire logic [DATA_W-1:0] ea_br8;
   wire logic [DATA_W-1:0] ea_br12;
   wire logic [DATA_W-1:0] ea_brreg;
   assign pc_base = sz_long ? (pc & EAG_PC_LONG_MASK) : pc;
   assign wb_postinc = DATA_W'(rn + size_step);
   assign ea_predec = DATA_W'(rn - size_step);
   assign ea_disp4 = DATA_W'(rn + disp4_sc);
   assign ea_indexed = DATA_W'(rn + r0);
   assign ea_gbr_disp = DATA_W'(global_base_register + disp8_sc);
   assign ea_gbr_idx = DATA_W'(global_base_register + r0);
   assign ea_pc_disp = DATA_W'(pc_base + disp8_sc);
   assign ea_br8 = DATA_W'(pc + br8_off);
   assign ea_br12 = DATA_W'(pc + br12_off);
   assign ea_brreg = DATA_W'(pc + rn);

   // ========================================================================
   // classification
   wire logic pc_byte;
   wire logic size_used;
   wire logic bad;
   wire logic is_mem;
   wire logic is_branch;
   wire logic is_wb;
   wire logic is_operand;
   assign pc_byte = m_pc_disp && sz_byte;
   assign size_used = m_postinc || m_predec || m_disp4 || m_gbr_disp || m_pc_disp;
   assign bad = pc_byte || (size_used && sz_bad);
   assign is_mem = !bad && (m_indirect || m_postinc || m_predec || m_disp4 ||
                            m_indexed || m_gbr_disp || m_gbr_idx || m_pc_disp);
   assign is_branch = m_br8 || m_br12 || m_brreg;
   assign is_wb = !bad && (m_postinc || m_predec);
   assign is_operand = m_direct || m_imm_zx || m_imm_sx || m_trap;

   // ========================================================================
   // address select
   wire logic [DATA_W-1:0] addr_sel;
   assign addr_sel = m_indirect ? rn :
                     m_postinc ? rn :
                     m_predec ? ea_predec :
                     m_disp4 ? ea_disp4 :
                     m_indexed ? ea_indexed :
                     m_gbr_disp ? ea_gbr_disp :
                     m_gbr_idx ? ea_gbr_idx :
                     m_pc_disp ? ea_pc_disp :
                     m_br8 ? ea_br8 :
                     m_br12 ? ea_br12 :
                     m_brreg ? ea_brreg : EAG_ZERO;

   // ========================================================================
   // write-back and operand select
   wire logic [DATA_W-1:0] wb_sel;
   wire logic [DATA_W-1:0] opnd_sel;
   assign wb_sel = m_postinc ? wb_postinc :
                   m_predec ? ea_predec : EAG_ZERO;
   assign opnd_sel = m_direct ? rn :
                     m_imm_zx ? imm_zx :
                     m_imm_sx ? imm_sx :
                     m_trap ? trap_off : EAG_ZERO;

   // ========================================================================
   // result registers
   logic done_r;
   logic mem_r;
   logic br_r;
   logic wb_en_r;
   logic opnd_en_r;
   logic ill_r;
   logic [DATA_W-1:0] addr_r;
   logic [DATA_W-1:0] wb_val_r;
   logic [DATA_W-1:0] opnd_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= i_req_valid;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         mem_r <= 1'b0;
         br_r <= 1'b0;
         wb_en_r <= 1'b0;
         opnd_en_r <= 1'b0;
         ill_r <= 1'b0;
      end else if (i_req_valid) begin
         mem_r <= is_mem;
         br_r <= is_branch;
         wb_en_r <= is_wb;
         opnd_en_r <= is_operand;
         ill_r <= bad;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         addr_r <= EAG_ZERO;
         wb_val_r <= EAG_ZERO;
         opnd_r <= EAG_ZERO;
      end else if (i_req_valid) begin
         addr_r <= is_mem || is_branch ? addr_sel : EAG_ZERO;
         wb_val_r <= is_wb ? wb_sel : EAG_ZERO;
         opnd_r <= opnd_sel;
      end
   end

   // ========================================================================
   // outputs
   assign o_done = done_r;
   assign o_mem_en = mem_r;
   assign o_branch_en = br_r;
   assign o_addr = addr_r;
   assign o_wb_en = wb_en_r;
   assign o_wb_value = wb_val_r;
   assign o_operand_en = opnd_en_r;
   assign o_operand = opnd_r;
   assign o_illegal = ill_r;
endmodule // eag_core

//--- bench/eag_dec_model.sv
// eag_dec_model: stand-in for the decoder and register file that feed requests.
// assumes the bench calls send and idle; every change lands on a rising edge.
`timescale 1ns/1ps
module eag_dec_model
   import eag_pkg::*;
(
   input wire logic i_ref_clk,
   output logic o_req_valid,
   output eag_req_t o_req
);
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end
   // =====================================
   // request held until the taking edge
   task automatic send(input eag_req_t r);
      @(posedge i_ref_clk);
      o_req_valid <= 1'b1;
      o_req <= r;
   endtask
   // stale fields scrambled once the strobe drops
   task automatic idle();
      @(posedge i_ref_clk);
      o_req_valid <= 1'b0;
      o_req <= ~o_req;
   endtask
endmodule // eag_dec_model

//--- bench/eag_core_props.sv
// eag_core_props: port-level checks of the effective address generator.
// assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ps
module eag_core_props
   import eag_pkg::*;
#(
   parameter int DATA_W = EAG_DATA_W
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire eag_req_t i_req,
   input wire logic o_done,
   input wire logic o_mem_en,
   input wire logic o_branch_en,
   input wire logic [DATA_W-1:0] o_addr,
   input wire logic o_wb_en,
   input wire logic [DATA_W-1:0] o_wb_value,
   input wire logic o_operand_en,
   input wire logic [DATA_W-1:0] o_operand,
   input wire logic o_illegal
);
   // =====================================
   // request decode helpers
   wire logic v = i_req_valid;
   wire eag_mode_t md = i_req.mode;
   wire logic [31:0] rn = i_req.gen_reg_n;
   wire logic [31:0] st = 32'h0000_0001 << i_req.size;
   wire logic ok = (i_req.size != 2'h3);
   wire logic [31:0] zx4 = {28'h000_0000, i_req.field[3:0]};
   wire logic [31:0] zx8 = {24'h00_0000, i_req.field[7:0]};
   wire logic [31:0] sx8 = {{24{i_req.field[7]}}, i_req.field[7:0]};
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   // =====================================
   // checks
   a_done_pulse: assert property (v |=> o_done)
      else $error("done missing after request");
   a_idle_hold: assert property (!v |=> !o_done && $stable(o_addr) && $stable(o_operand))
      else $error("outputs moved while idle");
   a_direct_op: assert property (
      v && md == EAG_M_DIRECT |=> o_operand_en && !o_mem_en && o_operand == $past(rn))
      else $error("direct operand wrong");
   a_indirect_addr: assert property (
      v && md == EAG_M_INDIRECT |=> o_mem_en && !o_wb_en && o_addr == $past(rn))
      else $error("indirect address wrong");
   a_postinc_wb: assert property (
      v && ok && md == EAG_M_POSTINC |=> o_addr == $past(rn) &&
      o_wb_value == $past(rn) + $past(st))
      else $error("post-increment wrong");
   a_predec_wb: assert property (
      v && ok && md == EAG_M_PREDEC |=> o_wb_en && o_addr == $past(rn) - $past(st) &&
      o_wb_value == o_addr)
      else $error("pre-decrement wrong");
   a_disp4_sum: assert property (
      v && ok && md == EAG_M_DISP4 |=> o_addr == $past(rn) + ($past(zx4) << $past(i_req.size)))
      else $error("short displacement wrong");
   a_gbr_disp: assert property (
      v && ok && md == EAG_M_GBR_DISP8 |=>
      o_addr == $past(i_req.global_base_reg) + ($past(zx8) << $past(i_req.size)))
      else $error("base displacement wrong");
   a_pc_long: assert property (
      v && md == EAG_M_PC_DISP8 && i_req.size == EAG_SZ_LONG |=>
      o_addr == ($past(i_req.pc) & EAG_PC_LONG_MASK) + ($past(zx8) << 2))
      else $error("pc longword load wrong");
   a_pc_byte: assert property (
      v && md == EAG_M_PC_DISP8 && i_req.size == EAG_SZ_BYTE |=>
      o_illegal && !o_mem_en && !o_wb_en)
      else $error("pc byte load not refused");
   a_br_short: assert property (
      v && md == EAG_M_BR_DISP8 |=> o_branch_en && o_addr == $past(i_req.pc) + ($past(sx8) << 1))
      else $error("short branch wrong");
   a_imm_sx: assert property (
      v && md == EAG_M_IMM_SX |=> o_operand_en && o_operand == $past(sx8))
      else $error("signed literal wrong");
   a_trap_ofs: assert property (
      v && md == EAG_M_IMM_TRAP |=> o_operand_en && o_operand == ($past(zx8) << 2) && !o_mem_en)
      else $error("trap offset wrong");
endmodule // eag_core_props

bind eag_core eag_core_props #(.DATA_W(DATA_W)) u_props (.i_ref_clk, .i_sys_rst, .i_req_valid,
   .i_req, .o_done, .o_mem_en, .o_branch_en, .o_addr, .o_wb_en, .o_wb_value, .o_operand_en,
   .o_operand, .o_illegal);

//--- bench/effective_address_generator_tb_top.sv
// effective_address_generator_tb_top: self-checking bench for eag_core.
// assumes eag_dec_model feeds requests and eag_core_props is bound to the core.
`timescale 1ns/1ps
module effective_address_generator_tb_top;
   import eag_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic req_valid;
   eag_req_t req;
   logic o_done, o_mem_en, o_branch_en, o_wb_en, o_operand_en, o_illegal;
   logic [31:0] o_addr, o_wb_value, o_operand;
   logic [31:0] rn, r0, global_base_register, pc;
   int n_mismatch = 0;
   int num_checks = 0;
   wire eag_res_t res = {o_mem_en, o_branch_en, o_addr, o_wb_en, o_wb_value, o_operand_en,
      o_operand, o_illegal};
   wire logic [101:0] obs = {o_done, res};
   initial begin
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   eag_dec_model u_dec (.i_ref_clk(i_ref_clk), .o_req_valid(req_valid), .o_req(req));
   eag_core uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid),
      .i_req(req), .o_done(o_done), .o_mem_en(o_mem_en), .o_branch_en(o_branch_en),
      .o_addr(o_addr), .o_wb_en(o_wb_en), .o_wb_value(o_wb_value),
      .o_operand_en(o_operand_en), .o_operand(o_operand), .o_illegal(o_illegal));
   // =====================================
   // helpers
   task automatic chk(input string name, input logic [101:0] seen, input logic [101:0] want);
      num_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, want, seen);
      end
   endtask
   function automatic eag_req_t rq(input eag_mode_t m, input eag_size_t s, input logic [11:0] f);
      return '{m, s, f, rn, r0, global_base_register, pc};
   endfunction
   function automatic eag_res_t rm(input logic [31:0] a, input logic wb, input logic [31:0] wv);
      eag_res_t e;
      e = '0;
      e.mem_en = 1'b1;
      e.addr = a;
      e.wb_en = wb;
      e.wb_value = wv;
      return e;
   endfunction
   function automatic eag_res_t ma(input logic [31:0] a);
      return rm(a, 1'b0, '0);
   endfunction
   function automatic eag_res_t rb(input logic [31:0] a);
      eag_res_t e;
      e = '0;
      e.branch_en = 1'b1;
      e.addr = a;
      return e;
   endfunction
   function automatic eag_res_t ro(input logic [31:0] o);
      eag_res_t e;
      e = '0;
      e.operand_en = 1'b1;
      e.operand = o;
      return e;
   endfunction
   task automatic one(input string n, input eag_req_t r, input eag_res_t e);
      u_dec.send(r);
      u_dec.idle();
      #1;
      chk(n, obs, {1'b1, e});
   endtask
   // =====================================
   // scenarios
   task automatic t_reset();
      #1;
      chk("rst", obs, '0);
      rn = 32'h0000_0040;
      one("ind", rq(EAG_M_INDIRECT, EAG_SZ_LONG, 12'h000), ma(rn));
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk("rst2", obs, '0);
   endtask
   task automatic t_step();
      logic [31:0] st;
      for (int i = 0; i < 3; i++) begin
         st = 32'h0000_0001 << i;
         rn = 32'hFFFF_FFFF;
         u_dec.send(rq(EAG_M_POSTINC, eag_size_t'(i), 12'h000));
         rn = 32'h0000_0000;
         u_dec.send(rq(EAG_M_PREDEC, eag_size_t'(i), 12'h000));
         #1;
         chk("post", obs, {1'b1, rm(32'hFFFF_FFFF, 1'b1, st - 32'h0000_0001)});
         u_dec.idle();
         #1;
         chk("pre", obs, {1'b1, rm(-st, 1'b1, -st)});
         @(posedge i_ref_clk);
         #1;
         chk("hold", obs, {1'b0, rm(-st, 1'b1, -st)});
      end
   endtask
   task automatic t_disp();
      logic [31:0] e4;
      logic [31:0] e8;
      rn = 32'h0000_1000;
      global_base_register = 32'hFFFF_FF00;
      for (int i = 0; i < 3; i++) begin
         e4 = rn + (32'h0000_000F << i);
         e8 = global_base_register + (32'h0000_00FF << i);
         one("d4", rq(EAG_M_DISP4, eag_size_t'(i), 12'hFFF), ma(e4));
         one("g8", rq(EAG_M_GBR_DISP8, eag_size_t'(i), 12'hFFF), ma(e8));
      end
   endtask
   task automatic t_index();
      rn = 32'h8000_0000;
      r0 = 32'h8000_0004;
      global_base_register = 32'h0000_0010;
      one("idx", rq(EAG_M_INDEXED, EAG_SZ_BYTE, 12'h000), ma(32'h0000_0004));
      one("gix", rq(EAG_M_GBR_INDEXED, EAG_SZ_BYTE, 12'h000), ma(32'h8000_0014));
   endtask
   task automatic t_bad();
      eag_res_t e;
      e = '0;
      e.illegal = 1'b1;
      rn = 32'h0000_0100;
      r0 = 32'h0000_0020;
      one("pst3", rq(EAG_M_POSTINC, eag_size_t'(2'h3), 12'h000), e);
      one("idx3", rq(EAG_M_INDEXED, eag_size_t'(2'h3), 12'h000), ma(32'h0000_0120));
   endtask
   task automatic t_pc();
      eag_res_t e;
      e = '0;
      e.illegal = 1'b1;
      pc = 32'h0000_1003;
      one("pcw", rq(EAG_M_PC_DISP8, EAG_SZ_WORD, 12'hF80), ma(32'h0000_1103));
      one("pcl", rq(EAG_M_PC_DISP8, EAG_SZ_LONG, 12'hF80), ma(32'h0000_1200));
      one("pcb", rq(EAG_M_PC_DISP8, EAG_SZ_BYTE, 12'h001), e);
   endtask
   task automatic t_branch();
      pc = 32'h0000_1000;
      rn = 32'hFFFF_F000;
      one("b8n", rq(EAG_M_BR_DISP8, EAG_SZ_LONG, 12'hF80), rb(32'h0000_0F00));
      one("b8p", rq(EAG_M_BR_DISP8, EAG_SZ_LONG, 12'h07F), rb(32'h0000_10FE));
      one("b12n", rq(EAG_M_BR_DISP12, EAG_SZ_LONG, 12'h800), rb(32'h0000_0000));
      one("b12p", rq(EAG_M_BR_DISP12, EAG_SZ_LONG, 12'h7FF), rb(32'h0000_1FFE));
      one("brr", rq(EAG_M_BR_REG, EAG_SZ_LONG, 12'h000), rb(32'h0000_0000));
   endtask
   task automatic t_imm();
      rn = 32'hA5C3_0F96;
      one("dir", rq(EAG_M_DIRECT, EAG_SZ_LONG, 12'h000), ro(rn));
      one("zx", rq(EAG_M_IMM_ZX, EAG_SZ_LONG, 12'hF80), ro(32'h0000_0080));
      one("sx", rq(EAG_M_IMM_SX, EAG_SZ_LONG, 12'hF80), ro(32'hFFFF_FF80));
      one("sxp", rq(EAG_M_IMM_SX, EAG_SZ_LONG, 12'h07F), ro(32'h0000_007F));
      one("trp", rq(EAG_M_IMM_TRAP, EAG_SZ_LONG, 12'hFFF), ro(32'h0000_03FC));
   endtask
   // =====================================
   // verdict, sequence and watchdog
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rn = '0;
      r0 = '0;
      global_base_register = '0;
      pc = '0;
      repeat (3) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_step();
      t_disp();
      t_index();
      t_bad();
      t_pc();
      t_branch();
      t_imm();
      end_of_test();
   end
   initial begin
      repeat (2000) @(posedge i_ref_clk);
      n_mismatch++;
      end_of_test();
   end
endmodule // effective_address_generator_tb_top
